// >>> verilog/epph_regs.svh
`ifndef EPPH_REGS_SVH
`define EPPH_REGS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define EPPH_IDX_DATA 11'h000
`define EPPH_IDX_DSR 11'h001
`define EPPH_IDX_DCR 11'h002
`define EPPH_IDX_FIFO 11'h400
`define EPPH_IDX_CONFIG_B 11'h401
`define EPPH_IDX_ECR 11'h402

// ==========================================================
// field positions
`define EPPH_DCR_DIR 5
`define EPPH_DCR_ACKIE 4
`define EPPH_ECR_NERRIE 4
`define EPPH_ECR_DMA_TRANSFER_ENABLE 3
`define EPPH_ECR_SRV 2

// ==========================================================
// reset and fixed values
`define EPPH_DCR_RST 6'h00
`define EPPH_ECR_RST 3'h0
`define EPPH_CONFIG_A_VAL 8'h10
`define EPPH_RESP_OKAY 2'h0
`define EPPH_RESP_SLVERR 2'h2

// ==========================================================
// timing for the compatibility strobe
`define EPPH_CLK_MHZ 100
`define EPPH_SETUP_NS 500
`define EPPH_STROBE_NS 500
`define EPPH_SETUP_CYC ((`EPPH_SETUP_NS * `EPPH_CLK_MHZ + 999) / 1000)
`define EPPH_STROBE_CYC ((`EPPH_STROBE_NS * `EPPH_CLK_MHZ + 999) / 1000)

`endif

// >>> verilog/epph_pkg.sv
`default_nettype none
package epph_pkg;
    // ==========================================================
    // port modes held in the extended control register
    typedef enum logic [2:0] {
        EPPH_MODE_STD = 3'h0,
        EPPH_MODE_BIDIR = 3'h1,
        EPPH_MODE_FIFO = 3'h2,
        EPPH_MODE_ECP = 3'h3,
        EPPH_MODE_EPP = 3'h4,
        EPPH_MODE_RSVD = 3'h5,
        EPPH_MODE_TEST = 3'h6,
        EPPH_MODE_CFG = 3'h7
    } epph_mode_t;

    // forward engine states
    typedef enum logic [3:0] {
        FWD_IDLE = 4'h1,
        FWD_SETUP = 4'h2,
        FWD_STROBE = 4'h4,
        FWD_HOLD = 4'h8
    } epph_fwd_t;

    // reverse engine states
    typedef enum logic [2:0] {
        REV_IDLE = 3'h1,
        REV_REQ = 3'h2,
        REV_DONE = 3'h4
    } epph_rev_t;
endpackage : epph_pkg
`default_nettype wire

// >>> verilog/epph_port.sv
// Summary of operation
// - every port word is one byte
// - all FIFOs share one 16-byte buffer
// - reverse run-length byte expands following byte
// - forward strobe latches byte, interlocked with busy
// - host flow requests reverse bytes, throttles them
// - forward host flow tags address or data
// - in ECP direction request low reverse, high forward; other modes follow control bit 2
// - in ECP drive data only when forward acknowledged; other modes drive whenever forward
// - ECP active line held high in ECP
// - fault raises error interrupt, forward only
// - status and control readable in every mode
// - config B reflects IRQ, DMA, compress, level
// - legacy printer port outside ECP operation
// - no negotiation; DMA-capable burst both ways
// - compatibility strobe generated from FIFO contents
// - address FIFO bytes tagged and sent forward
// - mode field selects the eight port modes
// - control bit 5 sets direction except 000/010
`include "epph_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module epph_port #(
    parameter int ADDR_W = 13,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] cfg_irq_sel,
    input wire logic [2:0] cfg_dma_sel,
    output logic dma_req,
    output logic fault_irq,
    output logic [7:0] parallel_data_bus_o,
    input wire logic [7:0] parallel_data_bus_i,
    output logic parallel_data_bus_oe_n,
    output logic host_clock_line_n,
    output logic host_flow_line,
    output logic direction_request_line_n,
    output logic ecp_active_line,
    input wire logic periph_clock_line_n,
    input wire logic peripheral_flow_line,
    input wire logic direction_ack_line,
    input wire logic select_line,
    input wire logic peripheral_request_line_n
);
    import epph_pkg::*;

    localparam int CW = $clog2(DEPTH + 1);
    localparam int PW = $clog2(DEPTH);
    localparam logic [7:0] SETUP_CYC = 8'(`EPPH_SETUP_CYC);
    localparam logic [7:0] STROBE_CYC = 8'(`EPPH_STROBE_CYC);

    // ==========================================================
    // pin synchronisers
    logic [12:0] sync1_q;
    logic [12:0] sync2_q;
    logic periph_clock_line_s, busy_s, dack_s, sel_s, peripheral_request_line_s;
    logic [7:0] pd_s;

    // two flip-flops per link input; reset to idle levels so no false fault or ack
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 13'h1100;
            sync2_q <= 13'h1100;
        end else begin
            sync1_q <= {periph_clock_line_n, peripheral_flow_line, direction_ack_line, select_line,
                        peripheral_request_line_n, parallel_data_bus_i};
            sync2_q <= sync1_q;
        end
    end
    assign {periph_clock_line_s, busy_s, dack_s, sel_s, peripheral_request_line_s, pd_s} = sync2_q;

    // ==========================================================
    // control registers
    logic [5:0] dcr_q;
    logic [7:0] data_q;
    epph_mode_t mode_q;
    logic [4:2] ecr_q;
    logic dir_in, ecp_mode, fwd_run, rev_run, test_mode;

    assign dir_in = dcr_q[`EPPH_DCR_DIR] && mode_q != EPPH_MODE_STD && mode_q != EPPH_MODE_FIFO;
    assign ecp_mode = mode_q == EPPH_MODE_ECP;
    assign test_mode = mode_q == EPPH_MODE_TEST;
    assign fwd_run = mode_q == EPPH_MODE_FIFO || (ecp_mode && !dir_in && dack_s);
    assign rev_run = ecp_mode && dir_in;

    // ==========================================================
    // shared FIFO, one tag bit per byte
    // one common buffer
    logic [8:0] mem_q [DEPTH];
    logic [PW-1:0] wp_q, rp_q;
    logic [CW-1:0] cnt_q;
    logic [7:0] last_q;
    logic push, pop, full, empty;
    logic [8:0] push_word;

    assign full = cnt_q == CW'(DEPTH);
    assign empty = cnt_q == '0;

    // pointers, count and storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            last_q <= 8'h00;
        end else begin
            if (push) begin
                mem_q[wp_q] <= push_word;
                wp_q <= PW'(wp_q + 1'b1);
            end
            if (pop) begin
                rp_q <= PW'(rp_q + 1'b1);
                last_q <= mem_q[rp_q][7:0];
            end
            cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    logic aw_have_q, w_have_q;
    logic [10:0] aw_idx_q;
    logic [7:0] w_data_q;
    logic w_lane_q;
    logic wr_go, wr_ok, rd_go, rd_ok;
    logic [10:0] ar_idx;
    logic fifo_wr, afifo_wr, fifo_rd;

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign ar_idx = s_axi_araddr[12:2];

    // address decode, mode gated where the map says so
    function automatic logic idx_ok(input logic [10:0] idx, input epph_mode_t m);
        unique case (idx)
            `EPPH_IDX_DATA: idx_ok = m != EPPH_MODE_EPP && m != EPPH_MODE_RSVD;
            `EPPH_IDX_DSR, `EPPH_IDX_DCR, `EPPH_IDX_ECR: idx_ok = 1'b1;
            `EPPH_IDX_FIFO: idx_ok = m == EPPH_MODE_FIFO || m == EPPH_MODE_ECP || m == EPPH_MODE_TEST ||
                                     m == EPPH_MODE_CFG;
            `EPPH_IDX_CONFIG_B: idx_ok = m == EPPH_MODE_CFG;
            default: idx_ok = 1'b0;
        endcase
    endfunction

    assign wr_ok = idx_ok(aw_idx_q, mode_q);
    assign rd_ok = idx_ok(ar_idx, mode_q);
    assign afifo_wr = wr_go && wr_ok && w_lane_q && aw_idx_q == `EPPH_IDX_DATA && ecp_mode && !dir_in;
    assign fifo_wr = wr_go && wr_ok && w_lane_q && aw_idx_q == `EPPH_IDX_FIFO && !ecp_mode | !dir_in &&
                     (mode_q != EPPH_MODE_CFG) && aw_idx_q == `EPPH_IDX_FIFO && wr_ok && wr_go && w_lane_q;
    assign fifo_rd = rd_go && ar_idx == `EPPH_IDX_FIFO && (test_mode || rev_run);

    // write channel capture and response
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_idx_q <= 11'h000;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EPPH_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[12:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `EPPH_RESP_OKAY : `EPPH_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dcr_q <= `EPPH_DCR_RST;
            data_q <= 8'h00;
            mode_q <= EPPH_MODE_STD;
        end else if (wr_go && wr_ok && w_lane_q) begin
            if (aw_idx_q == `EPPH_IDX_DCR) begin
                dcr_q <= w_data_q[5:0];
            end
            if (aw_idx_q == `EPPH_IDX_DATA && !ecp_mode) begin
                data_q <= w_data_q;
            end
            if (aw_idx_q == `EPPH_IDX_ECR) begin
                mode_q <= epph_mode_t'(w_data_q[7:5]);
            end
        end
    end

    // ecr enables and service flag; hardware set wins over software clear
    logic srv_set;
    assign srv_set = ecr_q[`EPPH_ECR_DMA_TRANSFER_ENABLE] && (dir_in ? full : empty) &&
                     (mode_q == EPPH_MODE_FIFO || ecp_mode);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ecr_q <= `EPPH_ECR_RST;
        end else begin
            if (wr_go && wr_ok && w_lane_q && aw_idx_q == `EPPH_IDX_ECR) begin
                ecr_q <= w_data_q[4:2];
            end
            if (srv_set) begin
                ecr_q[`EPPH_ECR_SRV] <= 1'b1;
            end
        end
    end

    // read data mux
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (ar_idx)
            `EPPH_IDX_DATA: rd_byte = dir_in ? pd_s : data_q;
            `EPPH_IDX_DSR: rd_byte = {~busy_s, periph_clock_line_s, dack_s, sel_s, peripheral_request_line_s, 3'h0};
            `EPPH_IDX_DCR: rd_byte = {2'h0, dcr_q};
            `EPPH_IDX_FIFO: begin
                if (mode_q == EPPH_MODE_CFG) begin
                    rd_byte = `EPPH_CONFIG_A_VAL;
                end else if (!empty) begin
                    rd_byte = mem_q[rp_q][7:0];
                end else begin
                    rd_byte = last_q; // empty test FIFO re-reads last byte
                end
            end
            `EPPH_IDX_CONFIG_B: rd_byte = {1'b0, fault_irq, cfg_irq_sel, cfg_dma_sel};
            `EPPH_IDX_ECR: rd_byte = {mode_q, ecr_q, full, empty};
            default: rd_byte = 8'h00;
        endcase
    end

    // read channel, one byte per word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `EPPH_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_ok ? rd_byte : 8'h00};
            s_axi_rresp <= rd_ok ? `EPPH_RESP_OKAY : `EPPH_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // forward engine
    epph_fwd_t fwd_q;
    logic [7:0] fwd_data_q;
    logic fwd_cmd_q;
    logic [7:0] tmr_q;
    logic fwd_pop;

    assign fwd_pop = fwd_q == FWD_IDLE && fwd_run && !empty;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fwd_q <= FWD_IDLE;
            fwd_data_q <= 8'h00;
            fwd_cmd_q <= 1'b0;
            tmr_q <= 8'h00;
        end else begin
            if (tmr_q != 8'h00) begin
                tmr_q <= tmr_q - 8'h01;
            end
            unique case (fwd_q)
                FWD_IDLE: begin
                    if (fwd_pop) begin
                        fwd_data_q <= mem_q[rp_q][7:0];
                        // tagged byte sent as command or count
                        fwd_cmd_q <= mem_q[rp_q][8];
                        tmr_q <= SETUP_CYC;
                        fwd_q <= FWD_SETUP;
                    end
                end
                FWD_SETUP: begin
                    if (tmr_q == 8'h00 && !busy_s) begin
                        tmr_q <= STROBE_CYC;
                        fwd_q <= FWD_STROBE;
                    end
                end
                FWD_STROBE: begin
                    if (ecp_mode ? busy_s : tmr_q == 8'h00) begin
                        fwd_q <= FWD_HOLD;
                    end
                end
                FWD_HOLD: begin
                    fwd_q <= FWD_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // reverse engine with run-length expansion
    epph_rev_t rev_q;
    logic [7:0] rev_byte_q;
    logic [7:0] rle_q;
    logic rle_have_q;
    logic [7:0] rep_q;
    logic rev_push;

    assign rev_push = rep_q != 8'h00 && !full;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rev_q <= REV_IDLE;
            rev_byte_q <= 8'h00;
            rle_q <= 8'h00;
            rle_have_q <= 1'b0;
            rep_q <= 8'h00;
        end else begin
            if (rev_push) begin
                rep_q <= rep_q - 8'h01;
            end
            unique case (rev_q)
                REV_IDLE: begin
                    if (rev_run && !dack_s && !full && rep_q == 8'h00) begin
                        rev_q <= REV_REQ;
                    end
                end
                REV_REQ: begin
                    if (!periph_clock_line_s) begin
                        rev_q <= REV_DONE;
                        if (!busy_s) begin
                            if (!pd_s[7]) begin
                                rle_q <= {1'b0, pd_s[6:0]};
                                rle_have_q <= 1'b1;
                            end
                        end else begin
                            rev_byte_q <= pd_s;
                            rep_q <= rle_have_q ? rle_q + 8'h01 : 8'h01;
                            rle_have_q <= 1'b0;
                        end
                    end
                end
                REV_DONE: begin
                    if (periph_clock_line_s) begin
                        rev_q <= REV_IDLE;
                    end
                end
            endcase
        end
    end

    // FIFO port arbitration; directions never overlap
    assign push = (rev_run ? rev_push : (fifo_wr || afifo_wr)) && !full;
    assign push_word = rev_run ? {1'b0, rev_byte_q} : {afifo_wr, w_data_q};
    assign pop = (fwd_pop || fifo_rd) && !empty;

    // ==========================================================
    // pin drivers
    // ECP active line high in ECP
    assign ecp_active_line = ecp_mode ? 1'b1 : ~dcr_q[3];
    assign direction_request_line_n = ecp_mode ? ~dir_in : dcr_q[2];
    assign host_clock_line_n = (mode_q == EPPH_MODE_FIFO || ecp_mode) ? fwd_q != FWD_STROBE : ~dcr_q[0];
    assign host_flow_line = !ecp_mode ? ~dcr_q[1] : dir_in ? rev_q != REV_REQ : ~fwd_cmd_q;
    assign parallel_data_bus_o = (mode_q == EPPH_MODE_FIFO || ecp_mode) ? fwd_data_q : data_q;
    assign parallel_data_bus_oe_n = ecp_mode ? (dir_in || !dack_s) : dir_in;
    assign fault_irq = !ecr_q[`EPPH_ECR_NERRIE] && !peripheral_request_line_s && !dir_in;
    // DMA request while channel needs service
    assign dma_req = ecr_q[`EPPH_ECR_DMA_TRANSFER_ENABLE] && !ecr_q[`EPPH_ECR_SRV] &&
                     (mode_q == EPPH_MODE_FIFO || ecp_mode) && (dir_in ? !empty : !full);
endmodule : epph_port
`default_nettype wire

// >>> verification/epph_port_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// port checker
module epph_port_properties #(
    parameter int ADDR_W = 13
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic fault_irq,
    input wire logic [7:0] parallel_data_bus_o,
    input wire logic host_clock_line_n,
    input wire logic host_flow_line,
    input wire logic direction_request_line_n,
    input wire logic periph_clock_line_n,
    input wire logic peripheral_flow_line,
    input wire logic peripheral_request_line_n
);
    logic [ADDR_W-1:0] rd_addr_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // address of the read under way
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_addr_q <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_q <= s_axi_araddr;
        end
    end
    chk_dsr_low: assert property (s_axi_rvalid && rd_addr_q == 13'h0004 |-> s_axi_rdata[2:0] == 3'h0)
        else $error("status low bits not zero");
    chk_dcr_high: assert property (s_axi_rvalid && rd_addr_q == 13'h0008 |-> s_axi_rdata[7:6] == 2'h0)
        else $error("control high bits not zero");
    chk_strobe_gate: assert property ($fell(host_clock_line_n) |-> !$past(peripheral_flow_line, 3))
        else $error("strobe while peripheral busy");
    chk_fwd_stable: assert property (!host_clock_line_n && !$fell(host_clock_line_n) |->
        $stable(host_flow_line) && $stable(parallel_data_bus_o))
        else $error("tag or data moved under strobe");
    chk_rev_flow: assert property ($rose(host_flow_line) && !direction_request_line_n &&
        !$past(direction_request_line_n) |-> !$past(periph_clock_line_n, 2) || !$past(periph_clock_line_n, 3))
        else $error("host flow rose without peripheral clock");
    chk_fault_cause: assert property (fault_irq |->
        !$past(peripheral_request_line_n, 2) || !$past(peripheral_request_line_n, 3))
        else $error("fault interrupt without request pin");
    chk_b_block: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready))
        else $error("write response before address held");
    chk_r_block: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("read data without address taken");
    cover property ($fell(host_clock_line_n));
    cover property ($rose(host_flow_line) && !direction_request_line_n);
    cover property (fault_irq);
endmodule : epph_port_properties
`default_nettype wire

// >>> verification/epph_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// peripheral on the link
module epph_periph_model (
    input wire logic lclk,
    input wire logic rst,
    input wire logic host_clock_line_n,
    input wire logic host_flow_line,
    input wire logic direction_request_line_n,
    input wire logic ecp_active_line,
    input wire logic [7:0] parallel_data_bus_o,
    input wire logic parallel_data_bus_oe_n,
    output logic periph_clock_line_n,
    output logic peripheral_flow_line,
    output logic direction_ack_line,
    output logic [7:0] parallel_data_bus_i
);
    logic [8:0] rx_q[$];
    logic [8:0] tx_q[$];
    logic [8:0] cur;
    logic [7:0] drv;
    logic [1:0] rv;
    // wire level: host value when it drives, else ours
    assign parallel_data_bus_i = parallel_data_bus_oe_n ? drv : parallel_data_bus_o;
    // link handshakes, one step per link clock
    always @(posedge lclk or posedge rst) begin
        if (rst) begin
            periph_clock_line_n <= 1'b1;
            peripheral_flow_line <= 1'b0;
            direction_ack_line <= 1'b0;
            drv <= 8'h00;
            rv <= 2'h0;
        end else begin
            direction_ack_line <= direction_request_line_n;
            if (direction_request_line_n) begin
                drv <= ~drv;
                if (!host_clock_line_n && !peripheral_flow_line) begin
                    rx_q.push_back({host_flow_line, parallel_data_bus_o});
                    peripheral_flow_line <= 1'b1;
                end else if (host_clock_line_n) begin
                    peripheral_flow_line <= 1'b0;
                end
            end else if (!direction_ack_line) begin
                case (rv)
                    2'h0: if (ecp_active_line && !host_flow_line && tx_q.size() != 0) begin
                        cur = tx_q.pop_front();
                        drv <= cur[7:0];
                        peripheral_flow_line <= cur[8];
                        rv <= 2'h1;
                    end else begin
                        drv <= ~drv;
                    end
                    2'h1: begin
                        periph_clock_line_n <= 1'b0;
                        rv <= 2'h2;
                    end
                    2'h2: if (host_flow_line) begin
                        periph_clock_line_n <= 1'b1;
                        rv <= 2'h3;
                    end
                    default: begin
                        drv <= ~drv;
                        rv <= 2'h0;
                    end
                endcase
            end
        end
    end
endmodule : epph_periph_model
`default_nettype wire

// >>> verification/tb_top.sv
`include "epph_regs.svh"
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bench
module tb_top;
    import epph_pkg::*;
    localparam int ADDR_W = 13;
    logic clk = 1'b0, lclk = 1'b0, rst = 1'b1;
    logic [12:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [2:0] cfg_irq_sel = 3'h5, cfg_dma_sel = 3'h3;
    logic select_line = 1'b1, peripheral_request_line_n = 1'b1;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dma_req, fault_irq;
    logic [7:0] parallel_data_bus_o, parallel_data_bus_i, rd_v;
    logic parallel_data_bus_oe_n, host_clock_line_n, host_flow_line, direction_request_line_n, ecp_active_line;
    logic periph_clock_line_n, peripheral_flow_line, direction_ack_line;
    int fail_count = 0, checked = 0;
    epph_port epph_port_inst (.*);
    epph_periph_model epph_periph_model_inst (.*);
    // clocks
    always #5 clk = ~clk;
    initial begin
        #3;
        forever #40 lclk = ~lclk;
    end
    task automatic give_verdict;
        $display("TB: %0d errors, %0d checks", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [12:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_v = s_axi_rdata[7:0];
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic rdc(input logic [12:0] a, input logic [8:0] e);
        rd(a);
        check(9'(rd_v), e);
    endtask : rdc
    task automatic wait_rx(input int k);
        for (int i = 0; i < 5000 && epph_periph_model_inst.rx_q.size() < k; i++) @(posedge clk);
    endtask : wait_rx
    // watchdog
    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        give_verdict;
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc(13'h0008, 9'h000);
        rdc(13'h1008, 9'h001);
        rdc(13'h0004, 9'h0D8);
        wr(13'h0008, 8'hF5);
        rdc(13'h0008, 9'h035);
        check(9'(host_clock_line_n), 9'h000);
        wr(13'h0008, 8'h24);
        wr(13'h0000, 8'h5A);
        check(9'(parallel_data_bus_o), 9'h05A);
        check(9'(parallel_data_bus_oe_n), 9'h000);
        wr(13'h0010, 8'h00);
        check(9'(resp), 9'(`EPPH_RESP_SLVERR));
        rd(13'h1004);
        check(9'(resp), 9'(`EPPH_RESP_SLVERR));
        // configuration and test modes
        wr(13'h1008, 8'hE0);
        rdc(13'h1000, 9'(`EPPH_CONFIG_A_VAL));
        rdc(13'h1004, 9'h02B);
        wr(13'h1008, 8'hC0);
        for (int i = 0; i < 17; i++) wr(13'h1000, 8'(i + 8'h30));
        rdc(13'h1008, 9'h0C2);
        for (int i = 0; i < 16; i++) rdc(13'h1000, 9'(i + 8'h30));
        rdc(13'h1008, 9'h0C1);
        rdc(13'h1000, 9'h03F);
        // compatibility fifo, then ECP forward
        epph_periph_model_inst.rx_q.delete();
        wr(13'h0008, 8'h04);
        wr(13'h1008, 8'h40);
        wr(13'h1000, 8'h96);
        wait_rx(1);
        check(9'(epph_periph_model_inst.rx_q[0][7:0]), 9'h096);
        wr(13'h1008, 8'h60);
        check(9'(ecp_active_line), 9'h001);
        epph_periph_model_inst.rx_q.delete();
        wr(13'h0000, 8'h85);
        wr(13'h1000, 8'h3C);
        wr(13'h1000, 8'hC3);
        wr(13'h0000, 8'h05);
        wait_rx(4);
        check(epph_periph_model_inst.rx_q[0], 9'h085);
        check(epph_periph_model_inst.rx_q[1], 9'h13C);
        check(epph_periph_model_inst.rx_q[2], 9'h1C3);
        check(epph_periph_model_inst.rx_q[3], 9'h005);
        peripheral_request_line_n <= 1'b0;
        repeat (6) @(posedge clk);
        check(9'(fault_irq), 9'h001);
        check(9'(direction_request_line_n), 9'h001);
        // ECP reverse with a run-length count of two
        epph_periph_model_inst.tx_q = '{9'h002, 9'h1A7, 9'h111};
        wr(13'h0008, 8'h24);
        repeat (6) @(posedge clk);
        check(9'(fault_irq), 9'h000);
        check(9'(direction_request_line_n), 9'h000);
        check(9'(parallel_data_bus_oe_n), 9'h001);
        for (int i = 0; i < 3000 && (epph_periph_model_inst.tx_q.size() != 0 || epph_periph_model_inst.rv != 2'h0); i++)
            @(posedge clk);
        repeat (40) @(posedge clk);
        wr(13'h1008, 8'h68);
        check(9'(dma_req), 9'h001);
        for (int i = 0; i < 3; i++) rdc(13'h1000, 9'h0A7);
        rdc(13'h1000, 9'h011);
        rdc(13'h1008, 9'h069);
        check(9'(dma_req), 9'h000);
        give_verdict;
    end
endmodule : tb_top
bind epph_port epph_port_properties #(.ADDR_W(ADDR_W)) epph_port_properties_inst (.*);
`default_nettype wire
